// ===== design/image_loader_defines.vh
// Constants for the firmware image loader and vocoder port
// Function
// - FIFO absorbs continuous 10 MHz serial streaming with a 50 MHz main clock.
// - Largest image loads in under 250 ms, bounded only by serial rate.
// - Native images get memory protection automatically at activation.
// - No block processing until both length and address words arrived.
// - FIFO activation never sets programming flag; host polls ident instead.
// - Pass-through pointer forwards each later data block up to the next pointer to the vocoder.
// - Pass-through unavailable while aux port is in split mode.
// - After second pointer, checksums show the forwarded vocoder blocks.
// - Aux port dedicated select output is the vocoder chip select.
// - Aux port mode comes from bits 3..0 of its mode register.
// - Vocoder settings written at init and entry to idle, rx, tx.
// - Gain commands forwarded only in receive or transmit mode.
// - Default vocoder setup: 4-frame 80 ms FEC, 2.4k FEC, soft bits, throttle 1.
// - Transparent tone mode kept; discontinuous-tx and voice-activity modes never on.
// - Enable register bit 15 moves data-out and clock to general pins.
// - Codec control bit 0 enables the SPI codec path.
// - Host bus bytes and words travel most significant bit first.
// - 32-bit activation code via programming register, then device goes active.
`ifndef IMAGE_LOADER_DEFINES_VH
`define IMAGE_LOADER_DEFINES_VH

`define CLK_MHZ          50
`define LOAD_LIMIT_MS    250
// Host bus register addresses
`define A_TXFIFO         8'h79
`define A_CODEC          8'hA0
`define A_CHKB_LO        8'hA9
`define A_CHKB_HI        8'hAA
`define A_CHKA_LO        8'hB8
`define A_CHKA_HI        8'hB9
`define A_IDENT          8'hC5
`define A_PROG           8'hC8
// Values
`define PROT_VALUE       16'h007F
`define CODEC_EN_BIT     0
`define PTR_NORMAL       16'h4010
`define PTR_PASS         16'h400E
`define ACT_BLK_ADDR     16'hFFFF
// Arbitrary identity and activation values
`define IDENT_CODE       16'h5A5A
`define ACT_CODE         32'h1234_5678
`define BAD_ACT          16'hDEAD
`define AUX_MODE_SPLIT   4'h2
`define MODE_IDLE        4'h0
`define MODE_RX          4'h1
`define MODE_TX          4'h2
// Vocoder setup word: [1:0] frames-1, 2 pkt FEC, [4:3] rate, 5 FEC, 6 ext sync,
// [8:7] throttle, 9 ext codec, 10 irq, 11 soft bits, 12 tone transparent,
// 13 voice activity, 14 discontinuous tx
`define VOC_DEFAULT      16'h08AF
`define VOC_VOICE_ACT_BIT 13
`define VOC_DISC_TX_BIT  14
`define FIFO_DEPTH       4
`define FIFO_AW          2
`define BOOT_HOST        2'b11

`endif

// ===== design/image_loader.v
// Firmware image loader with host serial slave and vocoder aux port
`timescale 1ns/1ns
`include "image_loader_defines.vh"
module image_loader (
	input  wire        CLK_I,         // 50 MHz clock
	input  wire        NRST_I,        // Async reset, low
	input  wire [1:0]  BOOT_SEL_I,    // Boot select pins
	input  wire        CSN_I,         // Host bus select, low
	input  wire        SCLK_I,        // Host bus clock
	input  wire        CDATA_I,       // Host command data
	output wire        RDATA_O,       // Host reply data
	output wire        RDATA_OE_O,    // Reply data drive enable
	input  wire [3:0]  AUX_MODE_I,    // Aux port mode register bits
	input  wire        ALT_PINS_I,    // Vocoder enable reg bit 15
	input  wire [3:0]  MODE_I,        // Device operating mode
	input  wire [15:0] VOC_CFG_I,     // Host-stored vocoder settings
	input  wire        VOC_CFG_VLD_I, // Host settings present
	input  wire        GAIN_REQ_I,    // Gain command pulse
	input  wire [15:0] GAIN_I,        // Gain command word
	input  wire        I2S_EN_I,      // I2S codec mode selected
	input  wire        I2S_STEREO_I,  // I2S stereo requested
	input  wire [4:0]  I2S_BITS_I,    // I2S sample width
	output wire        AUX_CS_N_O,    // Vocoder chip select, low
	output wire        AUX_SDO_O,     // Aux data out pin
	output wire        AUX_SCLK_O,    // Aux clock pin
	output wire        GPA_O,         // General pin A
	output wire        GPB_O,         // General pin B
	output wire        PROG_FLAG_O,   // Programming flag
	output wire        PROTECT_O,     // Memory protection on
	output wire        CODEC_EN_O,    // SPI codec path enable
	output wire        ACTIVE_O,      // Device activated
	output wire        PASS_O,        // Pass-through active
	output wire        I2S_UNSUP_O    // Unsupported I2S setup
);

localparam L_LEN  = 4'b0001;
localparam L_ADDR = 4'b0010;
localparam L_DATA = 4'b0100;
localparam L_PTR  = 4'b1000;

function is_rd;
	input [7:0] a;
	begin
		is_rd = (a == `A_CHKB_LO) || (a == `A_CHKB_HI) || (a == `A_CHKA_LO) ||
			(a == `A_CHKA_HI) || (a == `A_IDENT);
	end
endfunction

function is_rxtx;
	input [3:0] m;
	begin
		is_rxtx = (m == `MODE_RX) || (m == `MODE_TX);
	end
endfunction

reg        boot_done_ff;
reg        host_load_ff;
reg        sclk_q_ff;
reg [4:0]  bcnt_ff;
reg [7:0]  addr_ff;
reg [15:0] wsh_ff;
reg [15:0] rsh_ff;
reg        rd_ff;
reg        rdata_ff;
reg        wr_stb_ff;
reg [15:0] wr_data_ff;
reg [15:0] mem_ff [0:`FIFO_DEPTH-1];
reg [`FIFO_AW-1:0] wp_ff;
reg [`FIFO_AW-1:0] rp_ff;
reg [`FIFO_AW:0]   cnt_ff;
reg [3:0]  st_ff;
reg [15:0] len_ff;
reg [31:0] sum_ff;
reg [31:0] chka_ff;
reg [31:0] chkb_ff;
reg        blk_ff;
reg        chk_vld_ff;
reg        ident_vld_ff;
reg        pt_ff;
reg        loaded_ff;
reg        protect_ff;
reg        codec_ff;
reg        act_half_ff;
reg [15:0] act_hi_ff;
reg        active_ff;
reg        bad_ff;
reg [3:0]  mode_q_ff;
reg        setup_pend_ff;
reg        gain_pend_ff;
reg [15:0] gain_ff;
reg        busy_ff;
reg [1:0]  ph_ff;
reg [3:0]  abit_ff;
reg [15:0] ash_ff;
reg        unsup_ff;

wire rise = SCLK_I & ~sclk_q_ff & ~CSN_I;
wire fall = ~SCLK_I & sclk_q_ff & ~CSN_I;
wire [7:0] nxt_addr = {addr_ff[6:0], CDATA_I};
wire [7:0] rsel = (bcnt_ff < 5'd8) ? nxt_addr : addr_ff;
reg  [15:0] rd_val;
wire [15:0] head = mem_ff[rp_ff];
wire split = (AUX_MODE_I == `AUX_MODE_SPLIT);
wire aux_free = ~busy_ff & ~setup_pend_ff & ~gain_pend_ff;
wire wr_fifo = wr_stb_ff & (addr_ff == `A_TXFIFO);
wire wr_codec = wr_stb_ff & (addr_ff == `A_CODEC);
wire wr_prog = wr_stb_ff & (addr_ff == `A_PROG);
wire push = wr_fifo & host_load_ff & ~loaded_ff & (cnt_ff != `FIFO_DEPTH);
// Forwarding stalls the parser so a vocoder word is never dropped
wire pop = (cnt_ff != 0) & ((st_ff != L_DATA) | ~pt_ff | aux_free);
wire st_setup = ~busy_ff & setup_pend_ff;
wire st_gain = ~busy_ff & ~setup_pend_ff & gain_pend_ff;
wire st_pt = pop & (st_ff == L_DATA) & pt_ff;
wire [15:0] cfg_raw = VOC_CFG_VLD_I ? VOC_CFG_I : `VOC_DEFAULT;
wire [31:0] sum_nxt = sum_ff + {16'h0000, head};
wire act_match = ({act_hi_ff, wr_data_ff} == `ACT_CODE);
wire mode_entry = active_ff & (MODE_I != mode_q_ff) &
	((MODE_I == `MODE_IDLE) | is_rxtx(MODE_I));
wire init_entry = wr_prog & act_half_ff & act_match & loaded_ff & ~active_ff;
reg  [15:0] cfg_word;

// Read mux for the reply shifter
always @*
begin
	case (rsel)
		`A_CHKB_LO: rd_val = bad_ff ? `BAD_ACT : (chk_vld_ff ? chkb_ff[15:0] : 16'h0000);
		`A_CHKB_HI: rd_val = chk_vld_ff ? chkb_ff[31:16] : 16'h0000;
		`A_CHKA_LO: rd_val = chk_vld_ff ? chka_ff[15:0] : 16'h0000;
		`A_CHKA_HI: rd_val = chk_vld_ff ? chka_ff[31:16] : 16'h0000;
		`A_IDENT:   rd_val = ident_vld_ff ? `IDENT_CODE : 16'h0000;
		default:    rd_val = 16'h0000;
	endcase
end

// Voice activity and discontinuous tx masked
always @*
begin
	cfg_word = cfg_raw;
	cfg_word[`VOC_DISC_TX_BIT] = 1'b0;
	cfg_word[`VOC_VOICE_ACT_BIT] = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Boot strap capture and host serial slave
always @(posedge CLK_I or negedge NRST_I)
begin
	if (!NRST_I)
	begin
		boot_done_ff <= 1'b0;
		host_load_ff <= 1'b0;
		sclk_q_ff    <= 1'b0;
		bcnt_ff      <= 5'h00;
		addr_ff      <= 8'h00;
		wsh_ff       <= 16'h0000;
		rsh_ff       <= 16'h0000;
		rd_ff        <= 1'b0;
		rdata_ff     <= 1'b0;
		wr_stb_ff    <= 1'b0;
		wr_data_ff   <= 16'h0000;
	end
	else
	begin
		if (!boot_done_ff)
		begin
			boot_done_ff <= 1'b1;
			host_load_ff <= (BOOT_SEL_I == `BOOT_HOST);
		end
		sclk_q_ff <= SCLK_I;
		wr_stb_ff <= 1'b0;
		if (CSN_I)
		begin
			bcnt_ff <= 5'h00;
			rd_ff   <= 1'b0;
		end
		else if (rise)
		begin
			if (bcnt_ff < 5'd8)
			begin
				addr_ff <= nxt_addr;
				bcnt_ff <= bcnt_ff + 5'd1;
				if (bcnt_ff == 5'd7 && is_rd(nxt_addr))
				begin
					rd_ff    <= 1'b1;
					rsh_ff   <= rd_val;
					rdata_ff <= rd_val[15];
				end
			end
			else
			begin
				bcnt_ff <= (bcnt_ff == 5'd23) ? 5'd8 : bcnt_ff + 5'd1;
				if (rd_ff)
					rsh_ff <= (bcnt_ff == 5'd23) ? rd_val : {rsh_ff[14:0], 1'b0};
				else
				begin
					wsh_ff <= {wsh_ff[14:0], CDATA_I};
					// streamed words, one strobe per 16 bits
					if (bcnt_ff == 5'd23)
					begin
						wr_stb_ff  <= 1'b1;
						wr_data_ff <= {wsh_ff[14:0], CDATA_I};
					end
				end
			end
		end
		else if (fall && rd_ff)
			rdata_ff <= rsh_ff[15];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Image FIFO; one pop per clock, or one per aux word while forwarding, outruns 16 serial bits per word at 10 MHz
// FIFO keeps pace
always @(posedge CLK_I or negedge NRST_I)
begin
	if (!NRST_I)
	begin
		wp_ff  <= {`FIFO_AW{1'b0}};
		rp_ff  <= {`FIFO_AW{1'b0}};
		cnt_ff <= {(`FIFO_AW+1){1'b0}};
	end
	else
	begin
		if (push)
		begin
			mem_ff[wp_ff] <= wr_data_ff;
			wp_ff <= wp_ff + 1'b1;
		end
		if (pop)
			rp_ff <= rp_ff + 1'b1;
		if (push && !pop)
			cnt_ff <= cnt_ff + 1'b1;
		else if (pop && !push)
			cnt_ff <= cnt_ff - 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Block parser, checksums, activation and protection
always @(posedge CLK_I or negedge NRST_I)
begin
	if (!NRST_I)
	begin
		st_ff        <= L_LEN;
		len_ff       <= 16'h0000;
		sum_ff       <= 32'h0000_0000;
		chka_ff      <= 32'h0000_0000;
		chkb_ff      <= 32'h0000_0000;
		blk_ff       <= 1'b0;
		chk_vld_ff   <= 1'b0;
		ident_vld_ff <= 1'b0;
		pt_ff        <= 1'b0;
		loaded_ff    <= 1'b0;
		protect_ff   <= 1'b0;
		codec_ff     <= 1'b0;
		act_half_ff  <= 1'b0;
		act_hi_ff    <= 16'h0000;
		active_ff    <= 1'b0;
		bad_ff       <= 1'b0;
	end
	else
	begin
		if (pop)
		begin
			case (st_ff)
				L_LEN:
				begin
					len_ff <= head;
					st_ff  <= L_ADDR;
				end
				L_ADDR:
				begin
					sum_ff <= 32'h0000_0000;
					if (head == `ACT_BLK_ADDR)
						st_ff <= L_PTR;
					else if (len_ff == 16'h0000)
						st_ff <= L_LEN;
					else
						st_ff <= L_DATA;
				end
				L_DATA:
				begin
					sum_ff <= sum_nxt;
					len_ff <= len_ff - 16'h0001;
					if (len_ff == 16'h0001)
					begin
						if (blk_ff)
							chkb_ff <= sum_nxt;
						else
							chka_ff <= sum_nxt;
						blk_ff <= ~blk_ff;
						st_ff  <= L_LEN;
					end
				end
				L_PTR:
				begin
					chk_vld_ff   <= 1'b1;
					ident_vld_ff <= 1'b1;
					blk_ff       <= 1'b0;
					st_ff        <= L_LEN;
					if (head == `PTR_PASS && !split && !pt_ff)
						pt_ff <= 1'b1;
					else
					begin
						pt_ff      <= 1'b0;
						loaded_ff  <= 1'b1;
						protect_ff <= 1'b1;
					end
				end
				default: st_ff <= L_LEN;
			endcase
		end
		if (wr_codec)
		begin
			codec_ff <= wr_data_ff[`CODEC_EN_BIT];
			if (wr_data_ff == `PROT_VALUE)
				protect_ff <= 1'b1;
		end
		if (wr_prog && loaded_ff && !active_ff && !bad_ff)
		begin
			act_half_ff <= ~act_half_ff;
			act_hi_ff   <= wr_data_ff;
			if (act_half_ff)
			begin
				if (act_match)
				begin
					active_ff    <= 1'b1;
					chk_vld_ff   <= 1'b0;
					ident_vld_ff <= 1'b0;
				end
				else
					bad_ff <= 1'b1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Vocoder control requests and aux serial engine
always @(posedge CLK_I or negedge NRST_I)
begin
	if (!NRST_I)
	begin
		mode_q_ff     <= `MODE_IDLE;
		setup_pend_ff <= 1'b0;
		gain_pend_ff  <= 1'b0;
		gain_ff       <= 16'h0000;
		busy_ff       <= 1'b0;
		ph_ff         <= 2'b00;
		abit_ff       <= 4'h0;
		ash_ff        <= 16'h0000;
		unsup_ff      <= 1'b0;
	end
	else
	begin
		mode_q_ff <= MODE_I;
		// setup on init and mode entry; new request wins over take
		setup_pend_ff <= init_entry | mode_entry | (setup_pend_ff & ~st_setup);
		// gain only in rx or tx
		if (GAIN_REQ_I && active_ff && is_rxtx(MODE_I))
		begin
			gain_pend_ff <= 1'b1;
			gain_ff      <= GAIN_I;
		end
		else if (st_gain)
			gain_pend_ff <= 1'b0;
		if (st_setup || st_gain || st_pt)
		begin
			busy_ff <= 1'b1;
			ph_ff   <= 2'b00;
			abit_ff <= 4'h0;
			ash_ff  <= st_setup ? cfg_word : (st_gain ? gain_ff : head);
		end
		else if (busy_ff)
		begin
			ph_ff <= ph_ff + 2'b01;
			if (ph_ff == 2'b11)
			begin
				abit_ff <= abit_ff + 4'h1;
				ash_ff  <= {ash_ff[14:0], 1'b0};
				if (abit_ff == 4'hF)
					busy_ff <= 1'b0;
			end
		end
		unsup_ff <= I2S_EN_I & (I2S_STEREO_I | (I2S_BITS_I != 5'd16));
	end
end

wire aux_clk = busy_ff & ph_ff[1];
wire aux_dat = busy_ff & ash_ff[15];

assign RDATA_O     = rdata_ff;
assign RDATA_OE_O  = rd_ff & ~CSN_I;
assign AUX_CS_N_O  = ~busy_ff;
assign AUX_SDO_O   = ALT_PINS_I ? 1'b0 : aux_dat;
assign AUX_SCLK_O  = ALT_PINS_I ? 1'b0 : aux_clk;
assign GPA_O       = ALT_PINS_I ? aux_dat : 1'b0;
assign GPB_O       = ALT_PINS_I ? aux_clk : 1'b0;
assign PROG_FLAG_O = 1'b0;
assign PROTECT_O   = protect_ff;
assign CODEC_EN_O  = codec_ff;
assign ACTIVE_O    = active_ff;
assign PASS_O      = pt_ff;
assign I2S_UNSUP_O = unsup_ff;

endmodule // image_loader

// ===== testbench/vocoder_model.sv
// Vocoder side of the aux serial port: collects 16-bit words
`timescale 1ns/1ns
module vocoder_model (
	input  wire        clk_i,  // System clock
	input  wire        cs_n_i, // Vocoder select, low
	input  wire        alt_i,  // Alternate pins chosen
	input  wire        sdo_i,  // Normal data pin
	input  wire        sclk_i, // Normal clock pin
	input  wire        gpa_i,  // Alternate data pin
	input  wire        gpb_i,  // Alternate clock pin
	output logic [15:0] word_o, // Last whole word
	output logic [7:0]  cnt_o   // Words taken
);
	logic [15:0] sh_ff = 16'h0000;
	logic        clk_d_ff = 1'b0;
	logic        cs_d_ff = 1'b1;
	wire         d = alt_i ? gpa_i : sdo_i;
	wire         c = alt_i ? gpb_i : sclk_i;
	initial cnt_o = 8'h00;
	initial word_o = 16'h0000;
	////////////////////////////////////////
	// select, pins, MSB first
	always @(posedge clk_i)
	begin
		clk_d_ff <= c;
		cs_d_ff <= cs_n_i;
		if (!cs_n_i && c && !clk_d_ff)
			sh_ff <= {sh_ff[14:0], d};
		// Word counts only when select ends, so a cut word is seen as a wrong value
		if (cs_n_i && !cs_d_ff)
		begin
			word_o <= sh_ff;
			cnt_o <= cnt_o + 8'h01;
		end
	end
endmodule // vocoder_model

// ===== testbench/image_loader_sva.sv
// Port checker for the image loader
`timescale 1ns/1ns
`include "image_loader_defines.vh"
module image_loader_sva (
	input wire       CLK_I,       // Clock
	input wire       NRST_I,      // Reset, low
	input wire       CSN_I,       // Host select
	input wire       RDATA_OE_O,  // Reply enable
	input wire [3:0] AUX_MODE_I,  // Aux mode
	input wire       ALT_PINS_I,  // Pin arrangement
	input wire [3:0] MODE_I,      // Device mode
	input wire       GAIN_REQ_I,  // Gain pulse
	input wire       AUX_CS_N_O,  // Vocoder select
	input wire       AUX_SDO_O,   // Normal data
	input wire       AUX_SCLK_O,  // Normal clock
	input wire       GPA_O,       // Alt data
	input wire       GPB_O,       // Alt clock
	input wire       PROG_FLAG_O, // Programming flag
	input wire       ACTIVE_O,    // Activated
	input wire       PASS_O       // Pass-through
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	wire        aux_clk = AUX_SCLK_O | GPB_O;
	logic [7:0] low_cnt_ff;
	always @(posedge CLK_I or negedge NRST_I)
		if (!NRST_I)
			low_cnt_ff <= 8'h00;
		else
			low_cnt_ff <= AUX_CS_N_O ? 8'h00 : low_cnt_ff + 8'h01;
	sequence s_clk_high;
		aux_clk [*2] ##1 !aux_clk;
	endsequence
	sequence s_word_start;
		##[0:140] $fell(AUX_CS_N_O);
	endsequence
	////////////////////////////////////////
	a_prog_flag_low: assert property (PROG_FLAG_O == 1'b0)
		else $error("programming flag set");
	a_cs_word_len: assert property ($rose(AUX_CS_N_O) |-> low_cnt_ff == 8'h40)
		else $error("aux select low length wrong");
	a_aux_bit_time: assert property ($rose(aux_clk) |-> s_clk_high)
		else $error("aux clock high time wrong");
	a_aux_clk_idle: assert property (AUX_CS_N_O && $past(AUX_CS_N_O) |-> !aux_clk)
		else $error("aux clock runs outside a word");
	a_unused_pair: assert property ($stable(ALT_PINS_I) |->
		(ALT_PINS_I ? !(AUX_SDO_O | AUX_SCLK_O) : !(GPA_O | GPB_O)))
		else $error("unused aux pin pair driven");
	a_pass_split: assert property ($rose(PASS_O) |-> $past(AUX_MODE_I) != `AUX_MODE_SPLIT)
		else $error("pass-through entered in split mode");
	a_setup_on_act: assert property ($rose(ACTIVE_O) |-> s_word_start)
		else $error("no setup word after activation");
	a_setup_on_mode: assert property (ACTIVE_O && $changed(MODE_I) && MODE_I < 4'h3
		|-> s_word_start)
		else $error("no setup word after mode entry");
	// A setup word queued by a recent mode entry or activation is not a gain word
	a_gain_in_idle: assert property (GAIN_REQ_I && MODE_I == `MODE_IDLE && $stable(MODE_I)
		&& $past(MODE_I, 2) == MODE_I && $stable(ACTIVE_O) && $past(AUX_CS_N_O)
		&& AUX_CS_N_O && !PASS_O |=> AUX_CS_N_O [*4])
		else $error("gain sent in idle");
	a_reply_select: assert property (RDATA_OE_O |-> !CSN_I)
		else $error("reply driven without select");
endmodule // image_loader_sva
bind image_loader image_loader_sva i_image_loader_sva (
	.CLK_I(CLK_I), .NRST_I(NRST_I), .CSN_I(CSN_I), .RDATA_OE_O(RDATA_OE_O),
	.AUX_MODE_I(AUX_MODE_I), .ALT_PINS_I(ALT_PINS_I), .MODE_I(MODE_I),
	.GAIN_REQ_I(GAIN_REQ_I), .AUX_CS_N_O(AUX_CS_N_O), .AUX_SDO_O(AUX_SDO_O),
	.AUX_SCLK_O(AUX_SCLK_O), .GPA_O(GPA_O), .GPB_O(GPB_O), .PROG_FLAG_O(PROG_FLAG_O),
	.ACTIVE_O(ACTIVE_O), .PASS_O(PASS_O)
);

// ===== testbench/image_loader_tb.sv
// Self-checking bench for the image loader
`timescale 1ns/1ns
`include "image_loader_defines.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module image_loader_tb;
	logic        CLK_I = 0, NRST_I = 0, CSN_I = 1, SCLK_I = 0, CDATA_I = 0;
	logic        ALT_PINS_I = 0, VOC_CFG_VLD_I = 0, GAIN_REQ_I = 0;
	logic        I2S_EN_I = 0, I2S_STEREO_I = 0;
	logic [1:0]  BOOT_SEL_I = `BOOT_HOST;
	logic [3:0]  AUX_MODE_I = 4'h0, MODE_I = `MODE_IDLE;
	logic [4:0]  I2S_BITS_I = 5'h10;
	logic [15:0] VOC_CFG_I = 16'h0000, GAIN_I = 16'h0000, rd = 16'h0000;
	logic [7:0]  base;
	wire         RDATA_O, RDATA_OE_O, AUX_CS_N_O, AUX_SDO_O, AUX_SCLK_O, GPA_O, GPB_O;
	wire         PROG_FLAG_O, PROTECT_O, CODEC_EN_O, ACTIVE_O, PASS_O, I2S_UNSUP_O;
	wire [15:0]  vword;
	wire [7:0]   vcnt;
	int          errors = 0, compares = 0, cyc = 0;
	image_loader i_image_loader (.CLK_I(CLK_I), .NRST_I(NRST_I), .BOOT_SEL_I(BOOT_SEL_I),
		.CSN_I(CSN_I), .SCLK_I(SCLK_I), .CDATA_I(CDATA_I), .RDATA_O(RDATA_O),
		.RDATA_OE_O(RDATA_OE_O), .AUX_MODE_I(AUX_MODE_I), .ALT_PINS_I(ALT_PINS_I),
		.MODE_I(MODE_I), .VOC_CFG_I(VOC_CFG_I), .VOC_CFG_VLD_I(VOC_CFG_VLD_I),
		.GAIN_REQ_I(GAIN_REQ_I), .GAIN_I(GAIN_I), .I2S_EN_I(I2S_EN_I),
		.I2S_STEREO_I(I2S_STEREO_I), .I2S_BITS_I(I2S_BITS_I), .AUX_CS_N_O(AUX_CS_N_O),
		.AUX_SDO_O(AUX_SDO_O), .AUX_SCLK_O(AUX_SCLK_O), .GPA_O(GPA_O), .GPB_O(GPB_O),
		.PROG_FLAG_O(PROG_FLAG_O), .PROTECT_O(PROTECT_O), .CODEC_EN_O(CODEC_EN_O),
		.ACTIVE_O(ACTIVE_O), .PASS_O(PASS_O), .I2S_UNSUP_O(I2S_UNSUP_O));
	vocoder_model i_vocoder_model (.clk_i(CLK_I), .cs_n_i(AUX_CS_N_O), .alt_i(ALT_PINS_I),
		.sdo_i(AUX_SDO_O), .sclk_i(AUX_SCLK_O), .gpa_i(GPA_O), .gpb_i(GPB_O),
		.word_o(vword), .cnt_o(vcnt));
	initial forever #10 CLK_I = ~CLK_I;
	always @(posedge CLK_I)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			tally_and_finish;
		end
	end
	////////////////////////////////////////
	// Host bus bit: three clocks low, three high, reply taken at the end of high
	// serial clock stays well below the main clock
	task hb_bit(input logic b);
		SCLK_I = 0;
		CDATA_I = b;
		repeat (3) @(negedge CLK_I);
		SCLK_I = 1;
		repeat (3) @(negedge CLK_I);
		// A released reply line is taken as the inverse, so it never matches by luck
		rd = {rd[14:0], RDATA_OE_O ? RDATA_O : ~RDATA_O};
	endtask
	task hb_start(input logic [7:0] a);
		CSN_I = 0;
		@(negedge CLK_I);
		for (int i = 7; i >= 0; i--) hb_bit(a[i]);
	endtask
	// Released command line shows the inverse so a stale level is never trusted
	task hb_end;
		CSN_I = 1;
		SCLK_I = 0;
		CDATA_I = ~CDATA_I;
		repeat (20) @(negedge CLK_I);
	endtask
	task automatic hb_wr(input logic [7:0] a, input logic [15:0] w[$]);
		hb_start(a);
		foreach (w[k]) for (int i = 15; i >= 0; i--) hb_bit(w[k][i]);
		hb_end;
	endtask
	task hb_chk(input logic [7:0] a, input logic [15:0] e);
		hb_start(a);
		`CHK("reply enable", a != 8'h55, RDATA_OE_O)
		repeat (16) hb_bit(1'b0);
		hb_end;
		if (a != 8'h55) `CHK("register", e, rd)
	endtask
	task wait_voc(input logic [7:0] c, input logic [15:0] w);
		for (int i = 0; i < 400 && vcnt !== c; i++) @(negedge CLK_I);
		`CHK("vocoder count", c, vcnt)
		`CHK("vocoder word", w, vword)
	endtask
	task gain_pulse;
		GAIN_I = 16'h4321;
		GAIN_REQ_I = 1;
		@(negedge CLK_I);
		GAIN_REQ_I = 0;
	endtask
	////////////////////////////////////////
	task t_load;
		`CHK("reset outputs", 5'h10, {AUX_CS_N_O, ACTIVE_O, PASS_O, PROTECT_O, CODEC_EN_O})
		hb_chk(8'h55, 16'h0000);
		hb_chk(`A_IDENT, 16'h0000);
		hb_wr(`A_TXFIFO, '{16'h0002, 16'h0000, 16'h1111, 16'h2222,
			16'h0001, 16'h0001, 16'h0F0F, 16'h0001});
		`CHK("pass after length", 1'b0, PASS_O)
		hb_wr(`A_TXFIFO, '{`ACT_BLK_ADDR, `PTR_PASS});
		`CHK("pass", 1'b1, PASS_O)
		hb_chk(`A_IDENT, `IDENT_CODE);
		hb_chk(`A_CHKA_LO, 16'h3333);
		hb_chk(`A_CHKA_HI, 16'h0000);
		hb_chk(`A_CHKB_LO, 16'h0F0F);
		hb_chk(`A_CHKB_HI, 16'h0000);
	endtask
	task t_pass;
		base = vcnt;
		hb_wr(`A_TXFIFO, '{16'h0001, 16'h0000, 16'hBEEF});
		wait_voc(base + 8'h01, 16'hBEEF);
		hb_wr(`A_TXFIFO, '{16'h0001, `ACT_BLK_ADDR, `PTR_NORMAL});
		`CHK("pass off", 1'b0, PASS_O)
		`CHK("protect", 1'b1, PROTECT_O)
		hb_chk(`A_CHKA_LO, 16'hBEEF);
		hb_chk(`A_CHKA_HI, 16'h0000);
	endtask
	task t_act;
		base = vcnt;
		hb_wr(`A_PROG, '{16'h1234, 16'h5678});
		`CHK("active", 1'b1, ACTIVE_O)
		wait_voc(base + 8'h01, `VOC_DEFAULT);
		hb_chk(`A_IDENT, 16'h0000);
	endtask
	task t_gain;
		base = vcnt;
		gain_pulse;
		repeat (150) @(negedge CLK_I);
		`CHK("gain in idle", base, vcnt)
		VOC_CFG_VLD_I = 1;
		VOC_CFG_I = 16'h7FFF;
		ALT_PINS_I = 1;
		@(negedge CLK_I);
		MODE_I = `MODE_RX;
		wait_voc(base + 8'h01, 16'h1FFF);
		gain_pulse;
		wait_voc(base + 8'h02, 16'h4321);
		MODE_I = `MODE_TX;
		wait_voc(base + 8'h03, 16'h1FFF);
		MODE_I = `MODE_IDLE;
		wait_voc(base + 8'h04, 16'h1FFF);
	endtask
	task t_codec_i2s;
		hb_wr(`A_CODEC, '{16'h0001});
		`CHK("codec enable", 1'b1, CODEC_EN_O)
		I2S_EN_I = 1;
		for (int k = 0; k < 3; k++)
		begin
			I2S_STEREO_I = (k == 1);
			I2S_BITS_I = (k == 2) ? 5'h08 : 5'h10;
			repeat (3) @(negedge CLK_I);
			`CHK("i2s unsupported", k != 0, I2S_UNSUP_O)
		end
	endtask
	task t_split;
		NRST_I = 0;
		AUX_MODE_I = `AUX_MODE_SPLIT;
		repeat (4) @(negedge CLK_I);
		NRST_I = 1;
		repeat (2) @(negedge CLK_I);
		`CHK("active after reset", 1'b0, ACTIVE_O)
		hb_wr(`A_TXFIFO, '{16'h0001, 16'h0000, 16'hAAAA});
		`CHK("protect before write", 1'b0, PROTECT_O)
		// legacy protection between last data block and activation block
		hb_wr(`A_CODEC, '{`PROT_VALUE});
		`CHK("legacy protect", 1'b1, PROTECT_O)
		hb_wr(`A_TXFIFO, '{16'h0001, `ACT_BLK_ADDR, `PTR_PASS});
		`CHK("pass in split", 1'b0, PASS_O)
		hb_chk(`A_IDENT, `IDENT_CODE);
		hb_chk(`A_CHKA_LO, 16'hAAAA);
	endtask
	task tally_and_finish;
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge CLK_I);
		NRST_I = 1;
		repeat (2) @(negedge CLK_I);
		t_load;
		t_pass;
		t_act;
		t_gain;
		t_codec_i2s;
		t_split;
		tally_and_finish;
	end
endmodule // image_loader_tb
